/* File: src/ebh_arbiter.sv */
// External bus handover arbiter of the processor.
`timescale 1ns/1ps
`include "ebh_map.svh"
module ebh_arbiter (
    // Clock and reset
    input  wire logic                   i_sys_clk,
    input  wire logic                   i_reset,
    // Request and reset pins
    input  wire logic                   i_bus_request_n,
    input  wire logic                   i_reset_n,
    // Emulator pins
    input  wire logic                   i_emulator_enable,
    input  wire logic                   i_emu_bus_request_n,
    input  wire logic                   i_emu_reset_n,
    // Mode pins
    input  wire logic [`EBH_MODE_W-1:0] i_mode_pins,
    // Core side
    input  wire logic                   i_ext_access_busy,
    input  wire logic                   i_ext_access_need,
    input  wire logic                   i_continue_mode,
    // Grant pins
    output logic                        o_bus_grant_n,
    output logic                        o_bus_grant_n_oe,
    output logic                        o_emu_bus_grant_n,
    output logic                        o_grant_hang_n,
    // Core controls
    output logic                        o_mem_drive_en,
    output logic                        o_core_halt,
    output logic                        o_chip_reset,
    output logic [`EBH_MODE_W-1:0]      o_mode_latched
);
    import ebh_pkg::*;

    ebh_state_t             state_reg;
    ebh_state_t             state_next;
    logic                   grant_reg;
    logic                   hang_reg;
    logic                   halt_reg;
    logic                   rst_seen_reg;
    logic [`EBH_MODE_W-1:0] mode_reg;
    ebh_sync_if             sif ();

    // Emulator pins replace the target pins while enabled.
    wire sel_req = i_emulator_enable ? ~i_emu_bus_request_n
                                     : ~i_bus_request_n;
    wire sel_rst = i_emulator_enable ? ~i_emu_reset_n
                                     : ~i_reset_n;
    assign sif.req_raw = sel_req;

    ebh_sync u_sync (
        .i_sys_clk (i_sys_clk),
        .i_reset   (i_reset),
        .sif       (sif)
    );

    wire req = sif.req_sync;
    // Grant waits for the end of a running access; it may fall between two.
    wire can_grant = req & ~i_ext_access_busy;

    // Chip reset does not gate arbitration, so the bus can be handed over
    // while the core is held in reset or booting.
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            EBH_OWN: begin
                if (req && i_ext_access_busy) begin
                    state_next = EBH_DRAIN;
                end else if (can_grant) begin
                    state_next = EBH_GRANTED;
                end
            end
            EBH_DRAIN: begin
                if (!req) begin
                    state_next = EBH_OWN;
                end else if (!i_ext_access_busy) begin
                    state_next = EBH_GRANTED;
                end
            end
            EBH_GRANTED: begin
                if (!req) begin
                    state_next = EBH_OWN;
                end
            end
            default: state_next = EBH_OWN;
        endcase
    end

    wire granted_next = (state_next == EBH_GRANTED);
    // Continue mode halts only when the core actually wants the bus.
    wire halt_next = granted_next &
                     (~i_continue_mode | i_ext_access_need);
    wire hang_next = granted_next & i_ext_access_need;

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            state_reg <= EBH_OWN;
            grant_reg <= 1'b0;
            hang_reg  <= 1'b0;
            halt_reg  <= 1'b0;
        end else begin
            state_reg <= state_next;
            grant_reg <= granted_next;
            hang_reg  <= hang_next;
            halt_reg  <= halt_next;
        end
    end

    // Mode pins are re-caught on every chip reset, emulator ones included.
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            rst_seen_reg <= 1'b0;
            mode_reg     <= `EBH_MODE_RST;
        end else begin
            rst_seen_reg <= sel_rst;
            if (sel_rst) begin
                mode_reg <= i_mode_pins;
            end
        end
    end

    assign o_chip_reset      = rst_seen_reg;
    assign o_mode_latched    = mode_reg;
    assign o_bus_grant_n     = ~grant_reg;
    assign o_bus_grant_n_oe  = ~i_emulator_enable;
    assign o_emu_bus_grant_n = ~(grant_reg & i_emulator_enable);
    assign o_grant_hang_n    = ~hang_reg;
    assign o_mem_drive_en    = ~grant_reg;
    assign o_core_halt       = halt_reg;

    // Grant follows an idle synchronised request by one cycle.
    grant_timing_a: assert property (@(posedge i_sys_clk)
        disable iff (i_reset)
        (state_reg == EBH_OWN && req && !i_ext_access_busy)
        |=> !o_bus_grant_n)
        else $error("grant missing one cycle after request");

    no_grant_busy_a: assert property (@(posedge i_sys_clk)
        disable iff (i_reset)
        (state_reg == EBH_OWN && i_ext_access_busy) |=> !grant_reg)
        else $error("grant during external access");

    // A request that met a running access is served once it ends.
    sequence drained_s;
        state_reg == EBH_DRAIN && req && !i_ext_access_busy;
    endsequence
    drain_grant_a: assert property (@(posedge i_sys_clk)
        disable iff (i_reset)
        drained_s |=> grant_reg)
        else $error("grant late after access end");

    // Release seen while granted; a cycle later the core has the bus back.
    sequence released_s;
        grant_reg && !req;
    endsequence
    sequence bus_back_s;
        !grant_reg && !hang_reg && o_mem_drive_en && !o_core_halt;
    endsequence
    release_a: assert property (@(posedge i_sys_clk)
        disable iff (i_reset)
        released_s |=> bus_back_s)
        else $error("grant held after release");

    // Floating always comes with a halt, unless continue mode was on.
    drive_float_a: assert property (@(posedge i_sys_clk)
        disable iff (i_reset)
        !o_bus_grant_n |-> (!o_mem_drive_en &&
            (o_core_halt || $past(i_continue_mode))))
        else $error("bus driven while granted");

    // The bus is only given away in a cycle free of external access.
    float_cause_a: assert property (@(posedge i_sys_clk)
        disable iff (i_reset)
        $rose(grant_reg) |-> $past(req && !i_ext_access_busy))
        else $error("grant without an idle request");

    // Continue mode keeps the core running until it wants the bus.
    continue_a: assert property (@(posedge i_sys_clk)
        disable iff (i_reset)
        (granted_next && i_continue_mode && !i_ext_access_need)
        |=> (grant_reg && !o_core_halt))
        else $error("halted in continue mode");

    // Hang only means something while the bus is away.
    hang_a: assert property (@(posedge i_sys_clk)
        disable iff (i_reset)
        (granted_next && i_ext_access_need) |=> (!o_grant_hang_n && halt_reg))
        else $error("grant hang missing");

    // A chip reset pin held low must not take the bus back.
    reset_free_a: assert property (@(posedge i_sys_clk)
        disable iff (i_reset)
        (sel_rst && state_reg == EBH_GRANTED && req) |=> grant_reg)
        else $error("handover stopped by chip reset");

    // Under emulation the normal grant floats and the emulator pin leads.
    emu_float_a: assert property (@(posedge i_sys_clk)
        disable iff (i_reset)
        i_emulator_enable |->
            (!o_bus_grant_n_oe && o_emu_bus_grant_n == ~grant_reg))
        else $error("normal grant driven under emulation");

    emu_idle_a: assert property (@(posedge i_sys_clk)
        disable iff (i_reset)
        !i_emulator_enable |-> (o_bus_grant_n_oe && o_emu_bus_grant_n))
        else $error("emulator grant driven while disabled");

    mode_latch_a: assert property (@(posedge i_sys_clk)
        disable iff (i_reset)
        sel_rst |=> (o_chip_reset && o_mode_latched == $past(i_mode_pins)))
        else $error("mode not relatched on reset");
endmodule

/* File: src/ebh_map.svh */
// Constants for the external bus handover block.
`ifndef EBH_MAP_SVH
`define EBH_MAP_SVH
`define EBH_MODE_W      3
`define EBH_MODE_RST    3'h0
`define EBH_SYNC_STAGES 2
`endif

/* File: src/ebh_pkg.sv */
// Types for the external bus handover block.
package ebh_pkg;
    typedef enum logic [1:0] {
        EBH_OWN     = 2'b00,
        EBH_DRAIN   = 2'b01,
        EBH_GRANTED = 2'b10
    } ebh_state_t;
endpackage

/* File: src/ebh_sync_if.sv */
// Interface carrying the selected request between synchroniser and arbiter.
`timescale 1ns/1ps
interface ebh_sync_if;
    logic req_raw;
    logic req_sync;
    modport src (output req_raw, input req_sync);
    modport dst (input req_raw, output req_sync);
endinterface

/* File: src/ebh_sync.sv */
// Two-flop synchroniser for the bus request level.
`timescale 1ns/1ps
`include "ebh_map.svh"
module ebh_sync (
    // Clock and reset
    input  wire logic  i_sys_clk,
    input  wire logic  i_reset,
    // Request level
    ebh_sync_if.dst    sif
);
    logic [`EBH_SYNC_STAGES-1:0] stage_reg;
    // Reset leaves the request idle; the pin is not sampled until reset ends.
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            stage_reg <= '0;
        end else begin
            stage_reg <= {stage_reg[0], sif.req_raw};
        end
    end
    assign sif.req_sync = stage_reg[`EBH_SYNC_STAGES-1];
endmodule

/* File: tb/ebh_master_model.sv */
// Outside bus master that asks for the external bus and uses it.
`timescale 1ns/1ps
module ebh_master_model (
    // Control
    input  wire logic i_want,
    input  wire logic i_emu_active,
    // Bus pins
    input  wire logic i_bus_grant_n,
    input  wire logic i_emu_bus_grant_n,
    output logic      o_bus_request_n,
    output logic      o_owns
);
    // The master frees the bus only by dropping its request.
    assign o_bus_request_n = !i_want;
    // Under emulation the target grant pin floats, so the master waits for
    // the grant given on the emulator side before it touches the bus.
    assign o_owns = !o_bus_request_n &&
                    (i_emu_active ? !i_emu_bus_grant_n : !i_bus_grant_n);
endmodule

/* File: tb/tb_external_bus_handover.sv */
// Self-checking testbench of the external bus handover arbiter.
`timescale 1ns/1ps
module tb_external_bus_handover;
    logic       i_sys_clk = 0, i_reset = 1, want = 0, rn = 1, ee = 0;
    logic       emu_bus_request_n = 1, ern = 1, busy = 0, need = 0, cm = 0;
    logic [2:0] mode = 3'h0, ml;
    logic       req_n, owns, g, goe, eg, h, de, halt, cr;
    logic       g_last = 1'b1;
    // A floated grant pin has no pull, so it shows the opposite of its
    // last driven level to catch a master that trusts it.
    wire        g_pin = goe ? g : ~g_last;
    integer     seed = 38132, errors = 0, n_tests = 0, n;
    always #10 i_sys_clk = !i_sys_clk;
    always @(posedge i_sys_clk)
        if (goe) g_last <= g;
    ebh_master_model ebh_master_model_i (.i_want(want),
        .i_emu_active(ee), .i_bus_grant_n(g_pin),
        .i_emu_bus_grant_n(eg), .o_bus_request_n(req_n), .o_owns(owns));
    ebh_arbiter ebh_arbiter_i (.i_sys_clk(i_sys_clk), .i_reset(i_reset),
        .i_bus_request_n(req_n), .i_reset_n(rn),
        .i_emulator_enable(ee), .i_emu_bus_request_n(emu_bus_request_n),
        .i_emu_reset_n(ern), .i_mode_pins(mode),
        .i_ext_access_busy(busy), .i_ext_access_need(need),
        .i_continue_mode(cm), .o_bus_grant_n(g), .o_bus_grant_n_oe(goe),
        .o_emu_bus_grant_n(eg), .o_grant_hang_n(h), .o_mem_drive_en(de),
        .o_core_halt(halt), .o_chip_reset(cr), .o_mode_latched(ml));
    task report_and_stop;
        $display("tests %0d errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Halt and hang levels expected once the bus is granted away.
    function automatic logic [1:0] core_exp(input logic c, input logic nd);
        return {~c | nd, ~nd};
    endfunction
    task chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Waits a bounded time for the selected grant to reach a level.
    task wt(input logic emu, input logic lvl);
        int k;
        for (k = 0; k < 8 && (emu ? eg : g) !== lvl; k++) @(negedge i_sys_clk);
        if (k == 8) begin
            errors++;
            $display("Error %0t: grant wait ran out", $time);
            report_and_stop();
        end
    endtask
    initial begin
        repeat (5) @(negedge i_sys_clk);
        i_reset = 0;
        want = 1;
        repeat (2) @(negedge i_sys_clk);
        chk({g, de, owns}, 3'b110);
        wt(0, 0);
        chk({g, de, halt, h, owns}, {2'b00, core_exp(0, 0), 1'b1});
        want = 0;
        wt(0, 1);
        chk({g, de, halt, h}, 4'b1101);
        $display("test idle grant done");
        cm = 1;
        want = 1;
        wt(0, 0);
        chk({halt, h}, core_exp(1, 0));
        need = 1;
        repeat (2) @(negedge i_sys_clk);
        chk({halt, h}, core_exp(1, 1));
        want = 0;
        wt(0, 1);
        chk({h, de, halt}, 3'b110);
        need = 0;
        cm = 0;
        $display("test continue mode done");
        repeat (4) begin
            busy = 1;
            want = 1;
            n = 4 + ($random(seed) & 7);
            repeat (n) @(negedge i_sys_clk);
            chk({g, de}, 2'b11);
            busy = 0;
            @(negedge i_sys_clk);
            chk({g, de}, 2'b00);
            // A random need bit decides whether a second access now waits for the bus.
            need = 1'($random(seed));
            @(negedge i_sys_clk);
            chk({g, h}, {1'b0, ~need});
            need = 0;
            want = 0;
            wt(0, 1);
        end
        $display("test busy access done");
        rn = 0;
        want = 1;
        wt(0, 0);
        chk({halt, cr}, 2'b11);
        want = 0;
        wt(0, 1);
        rn = 1;
        $display("test grant in reset done");
        want = 1;
        wt(0, 0);
        i_reset = 1;
        repeat (2) @(negedge i_sys_clk);
        chk({g, de, halt, h, cr}, 5'b11010);
        i_reset = 0;
        wt(0, 0);
        chk({g, de}, 2'b00);
        want = 0;
        wt(0, 1);
        $display("test block reset done");
        ee = 1;
        want = 1;
        rn = 0;
        // The emulator keeps its own lines idle while stepping, whatever
        // the target request and reset do.
        repeat (6) @(negedge i_sys_clk);
        chk({goe, eg, de, cr, owns}, 5'b01100);
        rn = 1;
        want = 0;
        emu_bus_request_n = 0;
        wt(1, 0);
        chk({goe, de}, 2'b00);
        want = 1;
        @(negedge i_sys_clk);
        chk(owns, 1);
        want = 0;
        emu_bus_request_n = 1;
        wt(1, 1);
        mode = 3'($random(seed));
        ern = 0;
        repeat (3) @(negedge i_sys_clk);
        chk({cr, ml}, {1'b1, mode});
        ern = 1;
        repeat (3) @(negedge i_sys_clk);
        chk({cr, ml}, {1'b0, mode});
        $display("test emulator done");
        report_and_stop();
    end
endmodule
